/* File: design/uhcs_top.sv */
// compound host state sequencer with wishbone register slave
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "uhcs_defs.svh"
module uhcs_top
    import uhcs_pkg::*;
#(
    parameter logic [`UHCS_TMR_W-1:0] RESET_CYCLES = `UHCS_TMR_W'(`UHCS_RESET_CYC),
    parameter logic [`UHCS_TMR_W-1:0] SUSPEND_CYCLES = `UHCS_TMR_W'(`UHCS_SUSPEND_CYC),
    parameter logic [`UHCS_TMR_W-1:0] RESUME_CYCLES = `UHCS_TMR_W'(`UHCS_RESUME_CYC),
    parameter logic [`UHCS_TMR_W-1:0] EOP_CYCLES = `UHCS_TMR_W'(`UHCS_EOP_CYC)
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`UHCS_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic line_hs_dev,
    input wire logic line_chirp_ok,
    input wire logic line_chirp_err,
    input wire logic line_wakeup,
    input wire logic line_vbus_err,
    output logic bus_reset_o,
    output logic resume_k_o,
    output logic suspend_o,
    output logic sof_en_o,
    output logic disc_det_en_o,
    output logic wake_det_en_o
);
    uhcs_state_t state_q;
    uhcs_state_t state_d;
    uhcs_cmd_t cmd_q;
    uhcs_cmd_t cmd_d;
    uhcs_cmd_t wr_code;
    logic [`UHCS_FLAG_W-1:0] flags_q;
    logic [`UHCS_FLAG_W-1:0] set_d;
    logic [`UHCS_FLAG_W-1:0] clr;
    logic [`UHCS_EV_W-1:0] ev_s;
    logic [`UHCS_EV_W-1:0] ev_prev_q;
    logic [`UHCS_EV_W-1:0] rise;
    logic [31:0] rd_mux;
    logic permit_q;
    logic wr_go;
    logic cmd_wr;
    logic launch;
    logic busy;
    logic hs;
    logic vbus_hit;
    logic chirp_bad;
    logic chains_op;

    uhcs_tmr_if t ();

    // ================================================================
    // submodules
    uhcs_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .async_in({line_vbus_err, line_wakeup, line_chirp_err, line_chirp_ok, line_hs_dev}),
        .sync_out(ev_s)
    );

    uhcs_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .t(t)
    );

    // ================================================================
    // line events: edges only, so a held level cannot re-arm a cleared flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            ev_prev_q <= '0;
        end else if (ce) begin
            ev_prev_q <= ev_s;
        end
    end

    assign rise = ev_s & ~ev_prev_q;
    assign hs = ev_s[`UHCS_EV_HS];
    assign busy = (state_q != UHCS_ST_IDLE) && (state_q != UHCS_ST_ERROR);
    assign vbus_hit = busy && rise[`UHCS_EV_VBUS];
    assign chirp_bad = hs && rise[`UHCS_EV_CHIRP_ERR];
    assign chains_op = (cmd_q == `UHCS_CMD_SUSPEND_THEN_OP) || (cmd_q == `UHCS_CMD_RESUME_THEN_OP);

    // ================================================================
    // wishbone classic slave: ack one cycle after the strobe, write at the ack edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    assign wr_go = ce && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign cmd_wr = wr_go && (wb_adr_i == `UHCS_OFF_CMD);
    assign wr_code = wb_dat_i[`UHCS_CMD_W-1:0];
    assign clr = (wr_go && (wb_adr_i == `UHCS_OFF_STATUS)) ? wb_dat_i[`UHCS_FLAG_W-1:0] : '0;

    // commands are only taken between phases; transient phases ignore them
    assign launch = cmd_wr && (wr_code != `UHCS_CMD_NONE) && !(state_q inside {UHCS_ST_RESET,
        UHCS_ST_SUSPENDING, UHCS_ST_RESUMING, UHCS_ST_RSM_EOP});

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        unique case (wb_adr_i)
            `UHCS_OFF_CMD: rd_mux[`UHCS_CMD_W-1:0] = cmd_q;
            `UHCS_OFF_PERMIT: rd_mux[0] = permit_q;
            `UHCS_OFF_STATUS: rd_mux[`UHCS_FLAG_W-1:0] = flags_q;
            `UHCS_OFF_STATE: rd_mux[`UHCS_ST_W-1:0] = state_q;
            default: rd_mux = '0;
        endcase
    end

    // ================================================================
    // sequencer next state, timer loads and flag sets
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        set_d = '0;
        t.load = 1'b0;
        t.value = `UHCS_TMR_ZERO;
        if (launch) begin
            cmd_d = wr_code;
            unique case (wr_code)
                `UHCS_CMD_BUS_RESET, `UHCS_CMD_RESET_THEN_OP: begin
                    state_d = UHCS_ST_RESET;
                    t.load = 1'b1;
                    t.value = RESET_CYCLES;
                end
                `UHCS_CMD_SUSPEND, `UHCS_CMD_SUSPEND_THEN_OP: begin
                    state_d = UHCS_ST_SUSPENDING;
                    t.load = 1'b1;
                    t.value = SUSPEND_CYCLES;
                end
                `UHCS_CMD_RESUME, `UHCS_CMD_RESUME_THEN_OP: begin
                    state_d = UHCS_ST_RESUMING;
                    t.load = 1'b1;
                    t.value = RESUME_CYCLES;
                end
                default: begin
                    state_d = UHCS_ST_OPER;
                    cmd_d = `UHCS_CMD_NONE;
                end
            endcase
        end else if (vbus_hit) begin
            // bus power lost: abandon whatever phase is running
            state_d = UHCS_ST_ERROR;
            cmd_d = `UHCS_CMD_NONE;
            set_d[`UHCS_F_VBUS_ERR] = 1'b1;
        end else begin
            unique case (state_q)
                UHCS_ST_RESET: begin
                    if (chirp_bad) begin
                        set_d[`UHCS_F_CHIRP_ERR] = 1'b1;
                        state_d = UHCS_ST_ERROR;
                        cmd_d = `UHCS_CMD_NONE;
                    end else begin
                        // full/low-speed devices never chirp, so only hs reports
                        set_d[`UHCS_F_CHIRP_OK] = hs && rise[`UHCS_EV_CHIRP_OK];
                        if (t.expired) begin
                            set_d[`UHCS_F_RESET_DONE] = 1'b1;
                            cmd_d = `UHCS_CMD_NONE;
                            state_d = (cmd_q == `UHCS_CMD_RESET_THEN_OP) ? UHCS_ST_OPER : UHCS_ST_IDLE;
                        end
                    end
                end
                UHCS_ST_SUSPENDING: begin
                    if (t.expired) begin
                        set_d[`UHCS_F_SUSPEND_DONE] = 1'b1;
                        state_d = UHCS_ST_SUSPENDED;
                        if (cmd_q == `UHCS_CMD_SUSPEND) begin
                            cmd_d = `UHCS_CMD_NONE;
                        end
                    end
                end
                UHCS_ST_SUSPENDED: begin
                    if (wake_det_en_o && rise[`UHCS_EV_WAKE]) begin
                        set_d[`UHCS_F_WAKE_SEEN] = 1'b1;
                        if (cmd_q == `UHCS_CMD_SUSPEND_THEN_OP) begin
                            state_d = UHCS_ST_RESUMING;
                            t.load = 1'b1;
                            t.value = RESUME_CYCLES;
                        end
                    end
                end
                UHCS_ST_RESUMING: begin
                    if (t.expired) begin
                        state_d = UHCS_ST_RSM_EOP;
                        t.load = 1'b1;
                        t.value = EOP_CYCLES;
                    end
                end
                UHCS_ST_RSM_EOP: begin
                    if (t.expired) begin
                        set_d[`UHCS_F_RESUME_DONE] = 1'b1;
                        cmd_d = `UHCS_CMD_NONE;
                        state_d = chains_op ? UHCS_ST_OPER : UHCS_ST_IDLE;
                    end
                end
                UHCS_ST_IDLE, UHCS_ST_OPER, UHCS_ST_ERROR: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    // ================================================================
    // state and active command
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= UHCS_ST_IDLE;
            cmd_q <= `UHCS_CMD_NONE;
        end else if (ce) begin
            state_q <= state_d;
            cmd_q <= cmd_d;
        end
    end

    // sticky status flags; a set in the clearing cycle wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_q <= '0;
        end else if (ce) begin
            flags_q <= (flags_q & ~clr) | set_d;
        end
    end

    // firmware permit bit; the sequencer never writes it
    always_ff @(posedge mclk) begin
        if (rst) begin
            permit_q <= 1'b0;
        end else if (wr_go && (wb_adr_i == `UHCS_OFF_PERMIT)) begin
            permit_q <= wb_dat_i[0];
        end
    end

    // ================================================================
    // line controls, registered from the next state so they align with it
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_reset_o <= 1'b0;
            resume_k_o <= 1'b0;
            suspend_o <= 1'b0;
            sof_en_o <= 1'b0;
            disc_det_en_o <= 1'b0;
            wake_det_en_o <= 1'b0;
        end else if (ce) begin
            bus_reset_o <= (state_d == UHCS_ST_RESET);
            resume_k_o <= (state_d == UHCS_ST_RESUMING);
            suspend_o <= (state_d == UHCS_ST_SUSPENDING) || (state_d == UHCS_ST_SUSPENDED);
            sof_en_o <= (state_d == UHCS_ST_OPER);
            // both detectors drop in the same edge that starts the K drive
            disc_det_en_o <= state_d inside {UHCS_ST_OPER, UHCS_ST_SUSPENDING, UHCS_ST_SUSPENDED};
            wake_det_en_o <= (state_d == UHCS_ST_SUSPENDED)
                && (permit_q || (cmd_d == `UHCS_CMD_SUSPEND_THEN_OP));
        end
    end

    // ================================================================
    // checks: helper counts cycles spent in bus reset
    logic [`UHCS_TMR_W-1:0] rst_len_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            rst_len_q <= `UHCS_TMR_ZERO;
        end else if (ce) begin
            rst_len_q <= (state_q == UHCS_ST_RESET) ? rst_len_q + `UHCS_TMR_ONE : `UHCS_TMR_ZERO;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_reset_launch: assert property (launch && wr_code == `UHCS_CMD_RESET_THEN_OP
        |=> state_q == UHCS_ST_RESET && bus_reset_o) else $error("reset command did not start bus reset");
    a_chirp_ok_set: assert property (ce && state_q == UHCS_ST_RESET && hs && rise[`UHCS_EV_CHIRP_OK]
        && !chirp_bad && !vbus_hit |=> flags_q[`UHCS_F_CHIRP_OK]) else $error("chirp ok not flagged");
    a_reset_then_op: assert property (ce && state_q == UHCS_ST_RESET && t.expired && !chirp_bad
        && !vbus_hit && cmd_q == `UHCS_CMD_RESET_THEN_OP
        |=> flags_q[`UHCS_F_RESET_DONE] && state_q == UHCS_ST_OPER ##1 sof_en_o) else $error("reset did not chain");
    a_fs_no_chirp: assert property (ce && state_q == UHCS_ST_RESET && !hs
        |=> !$rose(flags_q[`UHCS_F_CHIRP_OK]) && !$rose(flags_q[`UHCS_F_CHIRP_ERR])) else $error("chirp flag on fs");
    a_error_abort: assert property (ce && !launch && (vbus_hit || (state_q == UHCS_ST_RESET && chirp_bad))
        |=> state_q == UHCS_ST_ERROR && !bus_reset_o && !sof_en_o) else $error("error did not abort");
    a_reset_length: assert property (ce && state_q == UHCS_ST_RESET && t.expired && !chirp_bad && !vbus_hit
        |-> rst_len_q == RESET_CYCLES - `UHCS_TMR_ONE) else $error("bus reset length wrong");
    a_permit_kept: assert property (!(wr_go && wb_adr_i == `UHCS_OFF_PERMIT)
        |=> $stable(permit_q)) else $error("permit bit changed by hardware");
    a_auto_wake: assert property (state_q == UHCS_ST_SUSPENDED && cmd_q == `UHCS_CMD_SUSPEND_THEN_OP
        |-> wake_det_en_o) else $error("wakeup detection not armed");
    a_suspend_done: assert property (ce && state_q == UHCS_ST_SUSPENDING && t.expired && !vbus_hit
        |=> state_q == UHCS_ST_SUSPENDED && flags_q[`UHCS_F_SUSPEND_DONE]) else $error("suspend done missing");
    a_wake_resume: assert property (ce && !launch && !vbus_hit && state_q == UHCS_ST_SUSPENDED
        && cmd_q == `UHCS_CMD_SUSPEND_THEN_OP && rise[`UHCS_EV_WAKE]
        |=> flags_q[`UHCS_F_WAKE_SEEN] ##1 resume_k_o) else $error("wakeup did not start resume");
    a_wake_op: assert property (ce && !vbus_hit && state_q == UHCS_ST_RSM_EOP && t.expired
        && cmd_q == `UHCS_CMD_SUSPEND_THEN_OP |=> flags_q[`UHCS_F_RESUME_DONE] && state_q == UHCS_ST_OPER)
        else $error("suspend sequence did not reach operational");
    a_resume_op: assert property (ce && !vbus_hit && state_q == UHCS_ST_RSM_EOP && t.expired
        && cmd_q == `UHCS_CMD_RESUME_THEN_OP |=> flags_q[`UHCS_F_RESUME_DONE] && state_q == UHCS_ST_OPER)
        else $error("resume sequence did not reach operational");
    a_resume_quiet: assert property ($rose(resume_k_o)
        |-> !disc_det_en_o && !wake_det_en_o) else $error("detection left on during resume");
    a_flag_sticky: assert property (ce && clr == '0
        |=> (flags_q & $past(flags_q)) == $past(flags_q)) else $error("status flag lost");

    c_reset_op: cover property (state_q == UHCS_ST_RESET && state_d == UHCS_ST_OPER);
    c_wake_chain: cover property (state_q == UHCS_ST_SUSPENDED && state_d == UHCS_ST_RESUMING);
    c_resume_op: cover property (state_q == UHCS_ST_RSM_EOP && state_d == UHCS_ST_OPER);
    c_error: cover property (state_q != UHCS_ST_ERROR && state_d == UHCS_ST_ERROR);
endmodule : uhcs_top

/* File: design/uhcs_defs.svh */
// constants for the compound host state sequencer
`ifndef UHCS_DEFS_SVH
`define UHCS_DEFS_SVH

// ====================================================================
// register offsets (byte addresses) and widths
`define UHCS_ADR_W 5
`define UHCS_OFF_CMD 5'h00
`define UHCS_OFF_PERMIT 5'h04
`define UHCS_OFF_STATUS 5'h08
`define UHCS_OFF_STATE 5'h0C
`define UHCS_CMD_W 3
`define UHCS_ST_W 3
`define UHCS_FLAG_W 7

// ====================================================================
// command codes of the host state command field
`define UHCS_CMD_NONE 3'h0
`define UHCS_CMD_BUS_RESET 3'h1
`define UHCS_CMD_OPERATIONAL 3'h2
`define UHCS_CMD_SUSPEND 3'h3
`define UHCS_CMD_RESUME 3'h4
`define UHCS_CMD_RESET_THEN_OP 3'h5
`define UHCS_CMD_SUSPEND_THEN_OP 3'h6
`define UHCS_CMD_RESUME_THEN_OP 3'h7

// ====================================================================
// status flag positions
`define UHCS_F_CHIRP_OK 0
`define UHCS_F_CHIRP_ERR 1
`define UHCS_F_RESET_DONE 2
`define UHCS_F_SUSPEND_DONE 3
`define UHCS_F_RESUME_DONE 4
`define UHCS_F_WAKE_SEEN 5
`define UHCS_F_VBUS_ERR 6

// ====================================================================
// line event positions after synchronising
`define UHCS_EV_W 5
`define UHCS_EV_HS 0
`define UHCS_EV_CHIRP_OK 1
`define UHCS_EV_CHIRP_ERR 2
`define UHCS_EV_WAKE 3
`define UHCS_EV_VBUS 4

// ====================================================================
// phase times and their cycle counts
`define UHCS_CLK_MHZ 100
`define UHCS_T_RESET_US 10000
`define UHCS_T_SUSPEND_US 3000
`define UHCS_T_RESUME_US 20000
`define UHCS_T_EOP_US 100
`define UHCS_TMR_W 21
`define UHCS_TMR_ONE 21'h000001
`define UHCS_TMR_ZERO 21'h000000
`define UHCS_RESET_CYC (`UHCS_T_RESET_US * `UHCS_CLK_MHZ)
`define UHCS_SUSPEND_CYC (`UHCS_T_SUSPEND_US * `UHCS_CLK_MHZ)
`define UHCS_RESUME_CYC (`UHCS_T_RESUME_US * `UHCS_CLK_MHZ)
`define UHCS_EOP_CYC (`UHCS_T_EOP_US * `UHCS_CLK_MHZ)

`endif

/* File: design/uhcs_pkg.sv */
// types of the compound host state sequencer
package uhcs_pkg;
    typedef enum logic [2:0] {
        UHCS_ST_IDLE = 3'b000,
        UHCS_ST_RESET = 3'b001,
        UHCS_ST_OPER = 3'b010,
        UHCS_ST_SUSPENDING = 3'b011,
        UHCS_ST_SUSPENDED = 3'b100,
        UHCS_ST_RESUMING = 3'b101,
        UHCS_ST_RSM_EOP = 3'b110,
        UHCS_ST_ERROR = 3'b111
    } uhcs_state_t;
    typedef logic [2:0] uhcs_cmd_t;
endpackage : uhcs_pkg

/* File: design/uhcs_tmr_if.sv */
// phase timer carrier between sequencer and timer
`timescale 1ns/1ps
`include "uhcs_defs.svh"
interface uhcs_tmr_if;
    logic load;
    logic [`UHCS_TMR_W-1:0] value;
    logic expired;
    modport ctl (output load, output value, input expired);
    modport tmr (input load, input value, output expired);
endinterface : uhcs_tmr_if

/* File: design/uhcs_sync.sv */
// two-flop synchronisers for the line event inputs
`timescale 1ns/1ps
`include "uhcs_defs.svh"
module uhcs_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [`UHCS_EV_W-1:0] async_in,
    output logic [`UHCS_EV_W-1:0] sync_out
);
    // ================================================================
    // per-bit chain; first flop feeds only the second
    genvar i;
    generate
        for (i = 0; i < `UHCS_EV_W; i++) begin : g_bit
            logic meta_q;
            logic stab_q;
            always_ff @(posedge mclk) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    stab_q <= 1'b0;
                end else if (ce) begin
                    meta_q <= async_in[i];
                    stab_q <= meta_q;
                end
            end
            assign sync_out[i] = stab_q;
        end
    endgenerate
endmodule : uhcs_sync

/* File: design/uhcs_timer.sv */
// down-counting phase timer
`timescale 1ns/1ps
`include "uhcs_defs.svh"
module uhcs_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    uhcs_tmr_if.tmr t
);
    logic [`UHCS_TMR_W-1:0] cnt_q;

    // ================================================================
    // load sets a phase of value cycles; expired marks its last cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= `UHCS_TMR_ZERO;
        end else if (ce) begin
            if (t.load) begin
                cnt_q <= t.value;
            end else if (cnt_q != `UHCS_TMR_ZERO) begin
                cnt_q <= cnt_q - `UHCS_TMR_ONE;
            end
        end
    end

    assign t.expired = (cnt_q == `UHCS_TMR_ONE);
endmodule : uhcs_timer

/* File: tb/uhcs_dev_model.sv */
// behavioural usb device on the far side of the host port
`timescale 1ns/1ps
module uhcs_dev_model (
    input wire logic mclk,
    input wire logic hs,
    input wire logic bad_chirp,
    input wire logic wake_req,
    input wire logic vbus_bad,
    input wire logic bus_reset_o,
    input wire logic resume_k_o,
    input wire logic wake_det_en_o,
    output logic line_hs_dev = 1'b0,
    output logic line_chirp_ok = 1'b0,
    output logic line_chirp_err = 1'b0,
    output logic line_wakeup = 1'b0,
    output logic line_vbus_err = 1'b0
);
    int age_q = 0;
    // ==========================================
    // line events
    // chirp comes some cycles into reset, as a real device needs time to see it
    always @(posedge mclk) begin
        age_q <= bus_reset_o ? age_q + 1 : 0;
        line_hs_dev <= hs;
        line_chirp_ok <= hs && !bad_chirp && bus_reset_o && age_q > 3;
        line_chirp_err <= hs && bad_chirp && bus_reset_o && age_q > 3;
        line_wakeup <= wake_req && wake_det_en_o && !resume_k_o; // only while armed
        line_vbus_err <= vbus_bad;
    end
endmodule : uhcs_dev_model

/* File: tb/uhcs_top_bench.sv */
// self-checking bench for the compound host state sequencer
`timescale 1ns/1ps
module uhcs_top_bench;
    localparam logic [20:0] NR = 21'h14;
    localparam logic [20:0] NK = 21'h1E;
    logic mclk, rst, ce, cyc, stb, we, ack, hs, bad_chirp, wake_req, vbus_bad;
    logic [4:0] adr;
    logic [31:0] dat, rdat;
    logic lhs, lok, ler, lwk, lvb, brst, rk, sus, sof, disc, wdet;
    int n_errors = 0, cmp_count = 0, n_brst = 0, n_k = 0;
    // ==========================================
    // design and far-side device
    uhcs_top #(.RESET_CYCLES(NR), .SUSPEND_CYCLES(21'h0A), .RESUME_CYCLES(NK), .EOP_CYCLES(21'h05)) uhcs_top_i (
        .mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .line_hs_dev(lhs), .line_chirp_ok(lok), .line_chirp_err(ler), .line_wakeup(lwk),
        .line_vbus_err(lvb), .bus_reset_o(brst), .resume_k_o(rk), .suspend_o(sus),
        .sof_en_o(sof), .disc_det_en_o(disc), .wake_det_en_o(wdet));
    uhcs_dev_model uhcs_dev_model_i (.mclk(mclk), .hs(hs), .bad_chirp(bad_chirp), .wake_req(wake_req),
        .vbus_bad(vbus_bad), .bus_reset_o(brst), .resume_k_o(rk), .wake_det_en_o(wdet),
        .line_hs_dev(lhs), .line_chirp_ok(lok), .line_chirp_err(ler), .line_wakeup(lwk), .line_vbus_err(lvb));
    // ==========================================
    // clock and phase length counters
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (brst === 1'b1) n_brst++;
        if (rk === 1'b1) n_k++;
        if (rk === 1'b1) check({30'h0, disc, wdet}, 32'h0);
    end
    // ==========================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one classic cycle; held until ack is sampled high
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int i;
        i = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge mclk);
            i++;
        end while (ack !== 1'b1 && i < 50);
        q = rdat;
        if (i >= 50) n_errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        check(q, e);
    endtask : rd_chk
    // poll the state register under a bounded count
    task automatic wait_state(input logic [2:0] s);
        logic [31:0] q;
        int i;
        i = 0;
        do begin
            bus(5'h0C, 1'b0, 32'h0, q);
            i++;
        end while (q[2:0] !== s && i < 200);
        check(q, {29'h0, s});
    endtask : wait_state
    task automatic summarize;
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    // ==========================================
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        summarize;
    end
    // ==========================================
    // scenarios
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 5'h00;
        dat = 32'h0;
        hs = 1'b1;
        bad_chirp = 1'b0;
        wake_req = 1'b0;
        vbus_bad = 1'b0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(5'h00, 32'h0);
        rd_chk(5'h04, 32'h0);
        rd_chk(5'h08, 32'h0);
        rd_chk(5'h0C, 32'h0);
        rd_chk(5'h10, 32'h0);
        wr(5'h04, 32'h1);
        rd_chk(5'h04, 32'h1);
        wr(5'h04, 32'h0);
        n_brst = 0;
        wr(5'h00, 32'h5);
        rd_chk(5'h0C, 32'h1);
        wait_state(3'h2);
        check(32'(n_brst), 32'(NR));
        rd_chk(5'h08, 32'h5);
        check({28'h0, brst, sus, disc, sof}, 32'h3);
        rd_chk(5'h08, 32'h5);
        wr(5'h08, 32'h7F);
        rd_chk(5'h08, 32'h0);
        hs <= 1'b0;
        wr(5'h00, 32'h5);
        wait_state(3'h2);
        rd_chk(5'h08, 32'h4);
        wr(5'h08, 32'h7F);
        wr(5'h00, 32'h6);
        wait_state(3'h4);
        rd_chk(5'h08, 32'h8);
        check({29'h0, sus, disc, wdet}, 32'h7);
        rd_chk(5'h04, 32'h0);
        n_k = 0;
        wake_req <= 1'b1;
        wait_state(3'h2);
        wake_req <= 1'b0;
        rd_chk(5'h08, 32'h38);
        check(32'(n_k), 32'(NK));
        wr(5'h08, 32'h7F);
        n_k = 0;
        wr(5'h00, 32'h7);
        // freeze the sequencer mid-resume; the K phase stretches by exactly the frozen edges
        ce <= 1'b0;
        repeat (8) @(posedge mclk);
        ce <= 1'b1;
        wait_state(3'h2);
        rd_chk(5'h08, 32'h10);
        check(32'(n_k), 32'(NK) + 32'h8);
        wr(5'h08, 32'h7F);
        hs <= 1'b1;
        bad_chirp <= 1'b1;
        wr(5'h00, 32'h5);
        wait_state(3'h7);
        rd_chk(5'h08, 32'h2);
        bad_chirp <= 1'b0;
        wr(5'h08, 32'h7F);
        wr(5'h00, 32'h7);
        vbus_bad <= 1'b1;
        wait_state(3'h7);
        rd_chk(5'h08, 32'h40);
        vbus_bad <= 1'b0;
        summarize;
    end
endmodule : uhcs_top_bench
